//--- common/exec_pkg.sv
// exec_pkg: constants, operation codes and carrier types for the execution core.
// assumes: one clock domain; operands and I/O read data arrive with each command.
package exec_pkg;

  // ------------------------------------------------------------
  // widths and reset values
  // ------------------------------------------------------------
  localparam int PC_W = 16;
  localparam int STACK_AW = 4;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // ------------------------------------------------------------
  // status flag bit positions
  // ------------------------------------------------------------
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_I = 3'h7;

  // ------------------------------------------------------------
  // constants and I/O map
  // ------------------------------------------------------------
  localparam logic [7:0] MASK_ALL = 8'hFF;
  localparam logic [7:0] BIT_IO_LAST = 8'h1F;
  localparam logic [7:0] PORT_IO_LAST = 8'h3F;
  localparam logic [7:0] IO_DATA_OFFSET = 8'h20;
  localparam logic [1:0] MUL_UNSIGNED = 2'h0;
  localparam logic [1:0] MUL_SIGNED = 2'h1;
  localparam logic [1:0] MUL_MIXED = 2'h2;

  // ------------------------------------------------------------
  // extra busy cycles beyond the first clock
  // ------------------------------------------------------------
  localparam logic [1:0] WAIT_NONE = 2'h0;
  localparam logic [1:0] WAIT_WORD = 2'h1;
  localparam logic [1:0] WAIT_MUL = 2'h1;
  localparam logic [1:0] WAIT_JUMP = 2'h1;
  localparam logic [1:0] WAIT_CALL = 2'h2;
  localparam logic [1:0] WAIT_RETURN = 2'h3;
  localparam logic [1:0] WAIT_BRANCH = 2'h1;
  localparam logic [1:0] WAIT_SKIP_ONE = 2'h1;
  localparam logic [1:0] WAIT_SKIP_TWO = 2'h2;
  localparam logic [1:0] WAIT_IO_BIT = 2'h1;
  localparam logic [1:0] WAIT_DATA = 2'h1;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {fn_add, fn_sub, fn_and, fn_or, fn_xor} alu_fn_type;

  typedef enum logic [4:0] {
    op_add, op_sub, op_compare, op_and, op_or, op_bitwise_xor,
    op_mask_set_bits, op_mask_clear_bits, op_zero_register, op_fill_register,
    op_word_immediate_sum, op_word_immediate_minus, op_multiply,
    op_pointer_jump, op_pointer_subcall, op_subroutine_return,
    op_compare_skip_equal, op_skip_reg_bit, op_skip_io_bit,
    op_branch_flag, op_branch_signed, op_branch_unsigned,
    op_io_bit_write, op_port_in, op_port_out, op_data_load, op_data_store
  } op_type;

  typedef struct packed {
    op_type op;
    logic use_const;
    logic alt;
    logic [1:0] mul_kind;
    logic frac;
    logic next_two_words;
    logic [4:0] rd_idx;
    logic [7:0] rd_val;
    logic [7:0] rd_hi_val;
    logic [7:0] rr_val;
    logic [7:0] k;
    logic [6:0] offset;
    logic [2:0] bit_sel;
    logic [7:0] addr;
    logic [7:0] io_val;
    logic [15:0] z_val;
  } cmd_type;

  typedef struct packed {
    logic valid;
    logic pair;
    logic [4:0] idx;
    logic [15:0] data;
  } wb_type;

  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } io_wr_type;

endpackage : exec_pkg

//--- logic/exec_alu.sv
// exec_alu: 8-bit adder, subtractor and logic unit with its flags.
// assumes: purely combinational, driven from the command operands.
`timescale 1ns/1ps
`default_nettype none
module exec_alu
  import exec_pkg::*;
(
  input wire alu_fn_type fn_i,
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  input wire logic cin_i,
  output logic [7:0] res_o,
  output logic c_o,
  output logic h_o,
  output logic v_o,
  output logic n_o,
  output logic z_o
);

  // ------------------------------------------------------------
  // arithmetic and logic
  // ------------------------------------------------------------
  always_comb begin
    logic [8:0] sum;
    logic [4:0] low;
    sum = 9'h000;
    low = 5'h00;
    res_o = 8'h00;
    c_o = 1'b0;
    h_o = 1'b0;
    v_o = 1'b0;
    unique case (fn_i)
      fn_add: begin
        sum = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin_i};
        low = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin_i};
        res_o = sum[7:0];
        c_o = sum[8];
        h_o = low[4];
        v_o = (a_i[7] == b_i[7]) && (sum[7] != a_i[7]);
      end
      fn_sub: begin
        sum = {1'b0, a_i} - {1'b0, b_i} - {8'h00, cin_i};
        low = {1'b0, a_i[3:0]} - {1'b0, b_i[3:0]} - {4'h0, cin_i};
        res_o = sum[7:0];
        c_o = sum[8];
        h_o = low[4];
        v_o = (a_i[7] != b_i[7]) && (sum[7] != a_i[7]);
      end
      fn_and: res_o = a_i & b_i;
      fn_or: res_o = a_i | b_i;
      fn_xor: res_o = a_i ^ b_i;
      default: res_o = 8'h00;
    endcase
    n_o = res_o[7];
    z_o = (res_o == 8'h00);
  end

endmodule : exec_alu
`default_nettype wire

//--- logic/exec_stack_mem.sv
// exec_stack_mem: return address store with one write port and a registered read.
// assumes: read data appear one clock after the read address.
`timescale 1ns/1ps
`default_nettype none
module exec_stack_mem #(
  parameter int AW = 4,
  parameter int DW = 16
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [DW-1:0] wr_data_i,
  input wire logic [AW-1:0] rd_addr_i,
  output logic [DW-1:0] rd_data_o
);

  logic [DW-1:0] mem_reg [2**AW];

  // ------------------------------------------------------------
  // storage and read register
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (wr_en_i) begin
      mem_reg[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= '0;
    end else begin
      rd_data_o <= mem_reg[rd_addr_i];
    end
  end

endmodule : exec_stack_mem
`default_nettype wire

//--- logic/cpu_alu_branch_execution.sv
// cpu_alu_branch_execution: runs decoded alu, skip, jump, call, branch and I/O commands.
// assumes: decode supplies operands and the addressed I/O value until cmd_ready_o.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - add with optional carry, five flags, one clock
// - word immediate sum/minus on pair, two clocks
// - subtract with optional borrow, five flags, one clock
// - logic ops touch Z N V only
// - mask set ors, mask clear ands inverse
// - zero register by xor; fill keeps flags
// - multiplies write pair one:zero, Z C
// - fractional multiplies shift product left once
// - pointer jump loads Z, two clocks
// - pointer subcall pushes return, three clocks
// - compare skip equal, one to three clocks
// - compares set flags, store nothing
// - register bit skip on clear or set
// - I/O bit skip on clear or set
// - flag branch adds offset plus one
// - signed branches use N xor V
// - unsigned branches use carry
// - bit ops only reach I/O up to 1F
// - bit writes rewrite whole register
// - port ops up to 3F, data offset 20
// - extended I/O only through data space
module cpu_alu_branch_execution
  import exec_pkg::*;
#(
  parameter int STACK_AW_P = STACK_AW
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic cmd_valid_i,
  input wire cmd_type cmd_i,
  output logic cmd_ready_o,
  output wb_type wb_o,
  output io_wr_type io_wr_o,
  output logic [PC_W-1:0] pc_o,
  output logic [7:0] status_flags_o,
  output logic refused_o
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef enum logic [0:0] {st_issue, st_stall} phase_type;
  typedef struct packed {
    phase_type phase;
    logic [1:0] wait_cnt;
    logic pop_pend;
    logic [PC_W-1:0] pc;
    logic [STACK_AW_P-1:0] sp;
    logic [7:0] flags;
    logic ready;
    wb_type wb;
    io_wr_type iow;
    logic refused;
  } state_type;

  localparam logic [STACK_AW_P-1:0] SP_ONE = {{(STACK_AW_P-1){1'b0}}, 1'b1};
  localparam state_type STATE_RESET = '{
    phase: st_issue, wait_cnt: WAIT_NONE, pop_pend: 1'b0, pc: PC_RESET,
    sp: '0, flags: FLAGS_RESET, ready: 1'b1, wb: '0, iow: '0, refused: 1'b0};
  state_type state_reg, state_next;
  alu_fn_type alu_fn;
  logic [7:0] alu_b, alu_res;
  logic alu_c, alu_h, alu_v, alu_n, alu_z, st_wr_en;
  logic [PC_W-1:0] st_rd_data;

  // ------------------------------------------------------------
  // alu operand selection
  // ------------------------------------------------------------
  always_comb begin
    unique case (cmd_i.op)
      op_add: alu_fn = fn_add;
      op_sub, op_compare: alu_fn = fn_sub;
      op_and, op_mask_clear_bits: alu_fn = fn_and;
      op_or, op_mask_set_bits: alu_fn = fn_or;
      op_bitwise_xor, op_zero_register: alu_fn = fn_xor;
      default: alu_fn = fn_add;
    endcase
    if (cmd_i.op == op_mask_clear_bits) begin
      alu_b = MASK_ALL - cmd_i.k;
    end else if (cmd_i.op == op_mask_set_bits) begin
      alu_b = cmd_i.k;
    end else if (cmd_i.op == op_zero_register) begin
      alu_b = cmd_i.rd_val;
    end else begin
      alu_b = cmd_i.use_const ? cmd_i.k : cmd_i.rr_val;
    end
  end

  exec_alu u_alu (
    .fn_i(alu_fn),
    .a_i(cmd_i.rd_val),
    .b_i(alu_b),
    .cin_i(cmd_i.alt & state_reg.flags[FLAG_C]),
    .res_o(alu_res),
    .c_o(alu_c),
    .h_o(alu_h),
    .v_o(alu_v),
    .n_o(alu_n),
    .z_o(alu_z)
  );

  assign st_wr_en = (state_reg.phase == st_issue) && cmd_valid_i
                    && (cmd_i.op == op_pointer_subcall);

  exec_stack_mem #(
    .AW(STACK_AW_P),
    .DW(PC_W)
  ) u_stack (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .wr_en_i(st_wr_en),
    .wr_addr_i(state_reg.sp),
    .wr_data_i(state_reg.pc + 16'h0001),
    .rd_addr_i(state_reg.sp - SP_ONE),
    .rd_data_o(st_rd_data)
  );

  // ------------------------------------------------------------
  // execution
  // ------------------------------------------------------------
  always_comb begin
    logic [1:0] extra;
    logic take, is_skip, is_branch;
    logic [16:0] word;
    logic [8:0] ma, mb;
    logic signed [17:0] prod;
    logic [15:0] pr;
    logic [7:0] bitdata;
    extra = WAIT_NONE;
    take = 1'b0;
    is_skip = 1'b0;
    is_branch = 1'b0;
    word = 17'h00000;
    ma = 9'h000;
    mb = 9'h000;
    prod = 18'sh00000;
    pr = 16'h0000;
    bitdata = cmd_i.io_val;
    state_next = state_reg;
    state_next.wb.valid = 1'b0;
    state_next.iow.valid = 1'b0;
    state_next.refused = 1'b0;
    if (state_reg.phase == st_stall) begin
      if (state_reg.pop_pend) begin
        state_next.pc = st_rd_data;
        state_next.pop_pend = 1'b0;
      end
      state_next.wait_cnt = state_reg.wait_cnt - 2'h1;
      if (state_reg.wait_cnt == 2'h1) begin
        state_next.phase = st_issue;
      end
    end else if (cmd_valid_i) begin
      state_next.pc = state_reg.pc + 16'h0001;
      state_next.wb.pair = 1'b0;
      state_next.wb.idx = cmd_i.rd_idx;
      state_next.wb.data = {8'h00, alu_res};
      unique case (cmd_i.op)
        op_add, op_sub, op_compare: begin
          state_next.wb.valid = (cmd_i.op != op_compare);
          state_next.flags[FLAG_C] = alu_c;
          state_next.flags[FLAG_H] = alu_h;
          state_next.flags[FLAG_V] = alu_v;
          state_next.flags[FLAG_N] = alu_n;
          state_next.flags[FLAG_Z] = (cmd_i.op != op_add && cmd_i.alt) ?
                                     (alu_z & state_reg.flags[FLAG_Z]) : alu_z;
        end
        op_and, op_or, op_bitwise_xor, op_mask_set_bits, op_mask_clear_bits,
        op_zero_register: begin
          state_next.wb.valid = 1'b1;
          state_next.flags[FLAG_Z] = alu_z;
          state_next.flags[FLAG_N] = alu_n;
          state_next.flags[FLAG_V] = 1'b0;
        end
        op_fill_register: begin
          state_next.wb.valid = 1'b1;
          state_next.wb.data = {8'h00, MASK_ALL};
        end
        op_word_immediate_sum, op_word_immediate_minus: begin
          if (cmd_i.op == op_word_immediate_sum) begin
            word = {1'b0, cmd_i.rd_hi_val, cmd_i.rd_val} + {11'h000, cmd_i.k[5:0]};
            state_next.flags[FLAG_V] = ~cmd_i.rd_hi_val[7] & word[15];
          end else begin
            word = {1'b0, cmd_i.rd_hi_val, cmd_i.rd_val} - {11'h000, cmd_i.k[5:0]};
            state_next.flags[FLAG_V] = cmd_i.rd_hi_val[7] & ~word[15];
          end
          state_next.wb.valid = 1'b1;
          state_next.wb.pair = 1'b1;
          state_next.wb.data = word[15:0];
          state_next.flags[FLAG_C] = word[16];
          state_next.flags[FLAG_Z] = (word[15:0] == 16'h0000);
          state_next.flags[FLAG_N] = word[15];
          state_next.flags[FLAG_S] = word[15] ^ state_next.flags[FLAG_V];
          extra = WAIT_WORD;
        end
        op_multiply: begin
          ma = {(cmd_i.mul_kind != MUL_UNSIGNED) & cmd_i.rd_val[7], cmd_i.rd_val};
          mb = {(cmd_i.mul_kind == MUL_SIGNED) & cmd_i.rr_val[7], cmd_i.rr_val};
          prod = $signed(ma) * $signed(mb);
          pr = cmd_i.frac ? {prod[14:0], 1'b0} : prod[15:0];
          state_next.wb.valid = 1'b1;
          state_next.wb.pair = 1'b1;
          state_next.wb.idx = 5'h00;
          state_next.wb.data = pr;
          state_next.flags[FLAG_C] = prod[15];
          state_next.flags[FLAG_Z] = (pr == 16'h0000);
          extra = WAIT_MUL;
        end
        op_pointer_jump: begin
          state_next.pc = cmd_i.z_val;
          extra = WAIT_JUMP;
        end
        op_pointer_subcall: begin
          state_next.sp = state_reg.sp + SP_ONE;
          state_next.pc = cmd_i.z_val;
          extra = WAIT_CALL;
        end
        op_subroutine_return: begin
          state_next.sp = state_reg.sp - SP_ONE;
          state_next.pop_pend = 1'b1;
          if (cmd_i.alt) begin
            state_next.flags[FLAG_I] = 1'b1;
          end
          extra = WAIT_RETURN;
        end
        op_compare_skip_equal: begin
          is_skip = 1'b1;
          take = (cmd_i.rd_val == cmd_i.rr_val);
        end
        op_skip_reg_bit: begin
          is_skip = 1'b1;
          take = (cmd_i.rr_val[cmd_i.bit_sel] == cmd_i.alt);
        end
        op_skip_io_bit: begin
          if (cmd_i.addr > BIT_IO_LAST) begin
            state_next.refused = 1'b1;
          end else begin
            is_skip = 1'b1;
            take = (cmd_i.io_val[cmd_i.bit_sel] == cmd_i.alt);
          end
        end
        op_branch_flag: begin
          is_branch = 1'b1;
          take = (state_reg.flags[cmd_i.bit_sel] == cmd_i.alt);
        end
        op_branch_signed: begin
          is_branch = 1'b1;
          take = ((state_reg.flags[FLAG_N] ^ state_reg.flags[FLAG_V]) == cmd_i.alt);
        end
        op_branch_unsigned: begin
          is_branch = 1'b1;
          take = (state_reg.flags[FLAG_C] == cmd_i.alt);
        end
        op_io_bit_write: begin
          if (cmd_i.addr > BIT_IO_LAST) begin
            state_next.refused = 1'b1;
          end else begin
            bitdata[cmd_i.bit_sel] = cmd_i.alt;
            state_next.iow.valid = 1'b1;
            state_next.iow.addr = cmd_i.addr + IO_DATA_OFFSET;
            state_next.iow.data = bitdata;
            extra = WAIT_IO_BIT;
          end
        end
        op_port_in, op_port_out: begin
          if (cmd_i.addr > PORT_IO_LAST) begin
            state_next.refused = 1'b1;
          end else if (cmd_i.op == op_port_in) begin
            state_next.wb.valid = 1'b1;
            state_next.wb.data = {8'h00, cmd_i.io_val};
          end else begin
            state_next.iow.valid = 1'b1;
            state_next.iow.addr = cmd_i.addr + IO_DATA_OFFSET;
            state_next.iow.data = cmd_i.rd_val;
          end
        end
        op_data_load: begin
          state_next.wb.valid = 1'b1;
          state_next.wb.data = {8'h00, cmd_i.io_val};
          extra = WAIT_DATA;
        end
        op_data_store: begin
          if (cmd_i.addr < IO_DATA_OFFSET) begin
            state_next.wb.valid = 1'b1;
            state_next.wb.idx = cmd_i.addr[4:0];
            state_next.wb.data = {8'h00, cmd_i.rd_val};
          end else begin
            state_next.iow.valid = 1'b1;
            state_next.iow.addr = cmd_i.addr;
            state_next.iow.data = cmd_i.rd_val;
          end
          extra = WAIT_DATA;
        end
        default: state_next.refused = 1'b1;
      endcase
      if (is_skip && take) begin
        state_next.pc = state_reg.pc + (cmd_i.next_two_words ? 16'h0003 : 16'h0002);
        extra = cmd_i.next_two_words ? WAIT_SKIP_TWO : WAIT_SKIP_ONE;
      end
      if (is_branch && take) begin
        state_next.pc = state_reg.pc + 16'h0001 + {{9{cmd_i.offset[6]}}, cmd_i.offset};
        extra = WAIT_BRANCH;
      end
      if (extra != WAIT_NONE) begin
        state_next.phase = st_stall;
        state_next.wait_cnt = extra;
      end
    end
    state_next.ready = (state_next.phase == st_issue);
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign cmd_ready_o = state_reg.ready;
  assign wb_o = state_reg.wb;
  assign io_wr_o = state_reg.iow;
  assign pc_o = state_reg.pc;
  assign status_flags_o = state_reg.flags;
  assign refused_o = state_reg.refused;

endmodule : cpu_alu_branch_execution
`default_nettype wire

//--- sim/io_model.sv
// io_model: peripheral I/O bytes seen through data-space addresses.
// assumes: written by the core's io write port, read combinationally.
`timescale 1ns/1ps
`default_nettype none
module io_model
  import exec_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire io_wr_type io_wr_i,
  input wire logic [7:0] rd_addr_i,
  output logic [7:0] rd_data_o
);
  // ----
  // storage, one pending-flag byte
  // ----
  localparam logic [7:0] FLAG_ADDR = 8'h35;
  logic [7:0] mem [256];
  assign rd_data_o = mem[rd_addr_i];
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 256; i++) mem[i] <= 8'(i);
      mem[FLAG_ADDR] <= 8'h07;
    end else if (io_wr_i.valid) begin
      if (io_wr_i.addr == FLAG_ADDR) mem[FLAG_ADDR] <= mem[FLAG_ADDR] & ~io_wr_i.data;
      else mem[io_wr_i.addr] <= io_wr_i.data;
    end
  end
endmodule : io_model
`default_nettype wire

//--- sim/exec_checks_asserts.sv
// exec_checks: timing and range properties at the core's ports.
// assumes: bound into cpu_alu_branch_execution; one clock, active-low reset.
`timescale 1ns/1ps
`default_nettype none
module exec_checks
  import exec_pkg::*;
#(
  parameter int STACK_AW_P = STACK_AW
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic cmd_valid_i,
  input wire cmd_type cmd_i,
  input wire logic cmd_ready_o,
  input wire wb_type wb_o,
  input wire io_wr_type io_wr_o,
  input wire logic [PC_W-1:0] pc_o,
  input wire logic [7:0] status_flags_o,
  input wire logic refused_o
);
  // ----
  // properties
  // ----
  logic take;
  logic is_port;
  logic is_bit;
  assign take = cmd_valid_i && cmd_ready_o;
  assign is_port = cmd_i.op == op_port_in || cmd_i.op == op_port_out;
  assign is_bit = cmd_i.op == op_io_bit_write || cmd_i.op == op_skip_io_bit;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_mul_pair: assert property (
    take && cmd_i.op == op_multiply |=> wb_o.valid && wb_o.pair && wb_o.idx == 5'h00
    && !cmd_ready_o ##1 cmd_ready_o) else $error("multiply write wrong");
  a_jump_two: assert property (
    take && cmd_i.op == op_pointer_jump |=> pc_o == $past(cmd_i.z_val) && !cmd_ready_o
    ##1 cmd_ready_o) else $error("pointer jump wrong");
  a_call_three: assert property (
    take && cmd_i.op == op_pointer_subcall |=> !cmd_ready_o [*2] ##1 cmd_ready_o)
    else $error("subcall length wrong");
  a_return_four: assert property (
    take && cmd_i.op == op_subroutine_return |=> !cmd_ready_o [*3] ##1 cmd_ready_o)
    else $error("return length wrong");
  a_bit_range: assert property (
    take && is_bit && cmd_i.addr > BIT_IO_LAST |=> refused_o && !io_wr_o.valid
    && cmd_ready_o) else $error("bit op range not refused");
  a_port_range: assert property (
    take && is_port && cmd_i.addr > PORT_IO_LAST |=> refused_o && !io_wr_o.valid)
    else $error("port range not refused");
  a_port_offset: assert property (
    take && cmd_i.op == op_port_out && cmd_i.addr <= PORT_IO_LAST |=> io_wr_o.valid
    && io_wr_o.addr == 8'($past(cmd_i.addr) + IO_DATA_OFFSET)) else $error("port addr wrong");
  a_logic_keeps: assert property (
    take && cmd_i.op inside {op_and, op_or, op_bitwise_xor, op_mask_set_bits,
    op_mask_clear_bits, op_zero_register} |=> (status_flags_o & 8'h21)
    == ($past(status_flags_o) & 8'h21)) else $error("logic op changed C or H");
  a_fill_keeps: assert property (
    take && cmd_i.op == op_fill_register |=> $stable(status_flags_o) && wb_o.valid
    && wb_o.data[7:0] == MASK_ALL) else $error("fill wrong");
  a_branch_keeps: assert property (
    take && cmd_i.op inside {op_branch_flag, op_branch_signed, op_branch_unsigned}
    |=> $stable(status_flags_o)) else $error("branch changed flags");
  a_signed_idle: assert property (
    take && cmd_i.op == op_branch_signed
    && cmd_i.alt != (status_flags_o[FLAG_N] ^ status_flags_o[FLAG_V])
    |=> cmd_ready_o && pc_o == 16'($past(pc_o) + 16'h0001)) else $error("signed branch wrong");
  c_return: cover property (take && cmd_i.op == op_subroutine_return);
  c_refused: cover property (refused_o);
  c_frac: cover property (take && cmd_i.op == op_multiply && cmd_i.frac);
endmodule : exec_checks
bind cpu_alu_branch_execution exec_checks #(.STACK_AW_P(STACK_AW_P)) exec_checks_inst (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
  .cmd_ready_o(cmd_ready_o), .wb_o(wb_o), .io_wr_o(io_wr_o), .pc_o(pc_o),
  .status_flags_o(status_flags_o), .refused_o(refused_o));
`default_nettype wire

//--- sim/cpu_alu_branch_execution_tb_top.sv
// testbench: issues decoded commands and checks results, flags, pc and clocks.
// assumes: io_model supplies the addressed I/O value with each command.
`timescale 1ns/1ps
`default_nettype none
module cpu_alu_branch_execution_tb_top
  import exec_pkg::*;
;
  logic core_clk_i = 0;
  logic rst_n_i = 0;
  logic cmd_valid_i = 0;
  cmd_type cmd_i = '0;
  cmd_type c;
  logic cmd_ready_o, refused_o, rf_s;
  wb_type wb_o, wb_s;
  io_wr_type io_wr_o, io_s;
  logic [15:0] pc_o;
  logic [7:0] status_flags_o, io_rd;
  logic [7:0] io_addr = 8'h00;
  int fail_count = 0;
  int check_count = 0;
  always #4 core_clk_i = ~core_clk_i;
  cpu_alu_branch_execution cpu_alu_branch_execution_inst (.core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o),
    .wb_o(wb_o), .io_wr_o(io_wr_o), .pc_o(pc_o), .status_flags_o(status_flags_o),
    .refused_o(refused_o));
  io_model io_model_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .io_wr_i(io_wr_o),
    .rd_addr_i(io_addr), .rd_data_o(io_rd));
  // ----
  // tasks
  // ----
  task automatic chk(input var logic [15:0] seen, input var logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  task automatic nc(input op_type op, input var logic [7:0] a, input var logic [7:0] b);
    c = '0;
    c.op = op;
    c.rd_val = a;
    c.rr_val = b;
    c.k = b;
  endtask : nc
  task automatic run(input int clk_n, input var logic [15:0] pc_e, input var logic [7:0] fl_e);
    int n;
    n = 1;
    io_addr = c.addr + 8'h20;
    @(negedge core_clk_i);
    c.io_val = io_rd;
    cmd_i = c;
    cmd_valid_i = 1;
    @(negedge core_clk_i);
    cmd_valid_i = 0;
    wb_s = wb_o;
    io_s = io_wr_o;
    rf_s = refused_o;
    while (cmd_ready_o !== 1'b1 && n < 8) begin
      @(negedge core_clk_i);
      n++;
    end
    chk(16'(n), 16'(clk_n));
    chk(pc_o, pc_e);
    chk({8'h00, status_flags_o}, {8'h00, fl_e});
  endtask : run
  task automatic wbc(input var logic pr, input var logic [4:0] ix, input var logic [15:0] d);
    chk({wb_s.valid, wb_s.pair, 9'h000, wb_s.idx}, {1'h1, pr, 9'h000, ix});
    chk(pr ? wb_s.data : {8'h00, wb_s.data[7:0]}, d);
  endtask : wbc
  task automatic iow(input var logic v, input var logic [7:0] a);
    chk({rf_s, io_s.valid, 6'h00, io_s.valid ? io_s.addr : 8'h00}, {~v, v, 6'h00, a});
  endtask : iow
  // ----
  // tests
  // ----
  initial begin
    repeat (2000) @(posedge core_clk_i);
    fail_count++;
    end_sim();
  end
  initial begin
    repeat (3) @(negedge core_clk_i);
    rst_n_i = 1;
    chk({cmd_ready_o, status_flags_o, 7'h00}, 16'h8000);
    nc(op_add, 8'h0F, 8'h01); c.rd_idx = 5'h03;
    run(1, 16'h0001, 8'h20);
    wbc(1'h0, 5'h03, 16'h0010);
    nc(op_add, 8'h80, 8'h80); c.alt = 1;
    run(1, 16'h0002, 8'h0B);
    nc(op_bitwise_xor, 8'hF0, 8'h0F);
    run(1, 16'h0003, 8'h05);
    wbc(1'h0, 5'h00, 16'h00FF);
    nc(op_fill_register, 8'h12, 8'h00); c.rd_idx = 5'h05;
    run(1, 16'h0004, 8'h05);
    wbc(1'h0, 5'h05, 16'h00FF);
    nc(op_compare, 8'h10, 8'h0F); c.alt = 1;
    run(1, 16'h0005, 8'h20);
    chk({15'h0000, wb_s.valid}, 16'h0000);
    nc(op_sub, 8'h00, 8'h01); c.use_const = 1;
    run(1, 16'h0006, 8'h25);
    wbc(1'h0, 5'h00, 16'h00FF);
    nc(op_multiply, 8'hFE, 8'h03); c.mul_kind = MUL_SIGNED;
    run(2, 16'h0007, 8'h25);
    wbc(1'h1, 5'h00, 16'hFFFA);
    nc(op_multiply, 8'h40, 8'h40); c.frac = 1;
    run(2, 16'h0008, 8'h24);
    wbc(1'h1, 5'h00, 16'h2000);
    nc(op_word_immediate_sum, 8'hFF, 8'h01); c.rd_idx = 5'h18;
    run(2, 16'h0009, 8'h20);
    wbc(1'h1, 5'h18, 16'h0100);
    nc(op_branch_signed, 8'h00, 8'h00); c.offset = 7'h03;
    run(2, 16'h000D, 8'h20);
    c.alt = 1;
    run(1, 16'h000E, 8'h20);
    nc(op_branch_unsigned, 8'h00, 8'h00); c.offset = 7'h7E;
    run(2, 16'h000D, 8'h20);
    nc(op_branch_flag, 8'h00, 8'h00); c.alt = 1; c.bit_sel = 3'h5; c.offset = 7'h02;
    run(2, 16'h0010, 8'h20);
    c.bit_sel = 3'h0;
    run(1, 16'h0011, 8'h20);
    nc(op_skip_reg_bit, 8'h80, 8'h80); c.alt = 1; c.bit_sel = 3'h7; c.next_two_words = 1;
    run(3, 16'h0014, 8'h20);
    nc(op_compare_skip_equal, 8'h55, 8'h55);
    run(2, 16'h0016, 8'h20);
    c.rr_val = 8'h54;
    run(1, 16'h0017, 8'h20);
    nc(op_skip_io_bit, 8'h00, 8'h00); c.addr = 8'h15; c.bit_sel = 3'h3;
    run(2, 16'h0019, 8'h20);
    nc(op_io_bit_write, 8'h00, 8'h00); c.addr = 8'h15;
    run(2, 16'h001A, 8'h20);
    iow(1'h1, 8'h35);
    chk({8'h00, io_s.data}, 16'h0006);
    chk({8'h00, io_rd}, 16'h0001);
    c.addr = 8'h20;
    run(1, 16'h001B, 8'h20);
    iow(1'h0, 8'h00);
    nc(op_port_out, 8'h00, 8'h5A); c.addr = 8'h40;
    run(1, 16'h001C, 8'h20);
    iow(1'h0, 8'h00);
    c.addr = 8'h0B;
    run(1, 16'h001D, 8'h20);
    iow(1'h1, 8'h2B);
    nc(op_data_store, 8'h00, 8'h3C); c.addr = 8'h60;
    run(2, 16'h001E, 8'h20);
    iow(1'h1, 8'h60);
    nc(op_pointer_subcall, 8'h00, 8'h00); c.z_val = 16'h0100;
    run(3, 16'h0100, 8'h20);
    nc(op_pointer_jump, 8'h00, 8'h00); c.z_val = 16'h0200;
    run(2, 16'h0200, 8'h20);
    nc(op_subroutine_return, 8'h00, 8'h00); c.alt = 1;
    run(4, 16'h001F, 8'hA0);
    nc(op_mask_clear_bits, 8'hF3, 8'h30);
    run(1, 16'h0020, 8'hA4);
    wbc(1'h0, 5'h00, 16'h00C3);
    nc(op_zero_register, 8'h5A, 8'h00);
    run(1, 16'h0021, 8'hA2);
    wbc(1'h0, 5'h00, 16'h0000);
    nc(op_word_immediate_minus, 8'h00, 8'h01);
    run(2, 16'h0022, 8'hB5);
    wbc(1'h1, 5'h00, 16'hFFFF);
    nc(op_port_in, 8'h00, 8'h00); c.addr = 8'h0A;
    run(1, 16'h0023, 8'hB5);
    wbc(1'h0, 5'h00, 16'h002A);
    nc(op_data_load, 8'h00, 8'h00); c.addr = 8'h50;
    run(2, 16'h0024, 8'hB5);
    wbc(1'h0, 5'h00, 16'h0070);
    end_sim();
  end
endmodule : cpu_alu_branch_execution_tb_top
`default_nettype wire
